// ===== core/slot_datapath_defines.vh
/*
  constants and functional notes for the slot datapath and packet queue.
  assumes one 100 MHz clock (sys_clk) and a synchronous active-high reset.
*/
`ifndef SLOT_DATAPATH_DEFINES_VH
`define SLOT_DATAPATH_DEFINES_VH
`define QUEUE_DEPTH 512
`define QUEUE_AW 9
`define QUEUE_EMPTY_BYTE 8'hFF
`define SUM_FULL 32'hFFFF_FFFF
`define MAX_FIELD_BYTES 3'h4
`define MAX_CIC_ORDER 3'h4
`define SLOT_COUNT 12
`define FACTOR_WIDTH 8
`endif

// ===== core/slot_datapath.v
/*
  per-slot datapath: pulse sums, decimation, result registers and 512-byte packet queue.
  assumes the slot sequencer on the same clock drives sample, slot and period strobes,
  runs only slots flagged in slotDue, and spaces periodEnd after the last slotEnd.
*/
`timescale 1ns/10ps
`include "slot_datapath_defines.vh"
module slot_datapath #(
  parameter NSLOT = `SLOT_COUNT,
  parameter ADCW = 14,
  parameter FW = `FACTOR_WIDTH
) (
  input wire sys_clk,
  input wire rst,
  input wire sampleValid,
  input wire sampleCh,
  input wire [ADCW-1:0] adcSample,
  input wire pulseNegateSelect,
  input wire digIntMode,
  input wire litRegion,
  input wire slotStart,
  input wire slotEnd,
  input wire [3:0] curSlot,
  input wire periodEnd,
  input wire [NSLOT-1:0] slotActive,
  input wire [NSLOT-1:0] ch2En,
  input wire [NSLOT-1:0] impulseMode,
  input wire [NSLOT-1:0] subsample,
  input wire [NSLOT*FW-1:0] decFactor,
  input wire [NSLOT*3-1:0] decType,
  input wire [NSLOT*5-1:0] darkShift,
  input wire [NSLOT*5-1:0] sigShift,
  input wire [NSLOT*3-1:0] darkSize,
  input wire [NSLOT*3-1:0] sigSize,
  input wire [NSLOT-1:0] holdRegs,
  input wire statusEn,
  input wire [7:0] statusByte,
  input wire popReq,
  input wire [3:0] rdSlot,
  input wire rdCh,
  input wire [NSLOT-1:0] dataFlagClr,
  input wire overrunClr,
  input wire underrunClr,
  output reg [7:0] fifoData,
  output reg [`QUEUE_AW:0] fifoCount,
  output reg queue_overrun_flag_unused_guard,
  output reg queueOverrunFlag,
  output reg queueUnderrunFlag,
  output reg [NSLOT-1:0] dataFlag,
  output reg [31:0] rdDark,
  output reg [31:0] rdSig,
  output wire [NSLOT-1:0] slotDue,
  output wire busy
);
  localparam S_IDLE = 2'd0;
  localparam S_FIN0 = 2'd1;
  localparam S_FIN1 = 2'd2;
  localparam W_IDLE = 2'd0;
  localparam W_DATA = 2'd1;
  localparam W_STAT = 2'd2;
  localparam NK = NSLOT * 2;

  reg [31:0] posSum [0:1];
  reg [31:0] negSum [0:1];
  reg [31:0] integ [0:NK*4-1];
  reg [31:0] combDly [0:NK*4-1];
  reg [31:0] bsDark [0:NK-1];
  reg [31:0] bsSig [0:NK-1];
  reg [31:0] intDark [0:NK-1];
  reg [31:0] intSig [0:NK-1];
  reg [31:0] latDark [0:NK-1];
  reg [31:0] latSig [0:NK-1];
  reg [31:0] stDark [0:NK-1];
  reg [31:0] stSig [0:NK-1];
  reg [NK-1:0] stRdy;
  reg [FW-1:0] decCnt [0:NSLOT-1];
  reg [FW-1:0] seqCnt [0:NSLOT-1];
  reg [7:0] qMem [0:`QUEUE_DEPTH-1];
  reg [`QUEUE_AW-1:0] wrPtr;
  reg [`QUEUE_AW-1:0] rdPtr;
  reg [1:0] finState;
  reg [3:0] finSlot;
  reg finDue;
  reg [1:0] wState;
  reg [3:0] wSlot;
  reg wCh;
  reg wFld;
  reg [1:0] wByte;
  integer i;
  integer j;
  // loop indices of the combinational blocks are kept apart from the clocked ones
  integer k;
  integer m;

  function [2:0] clampSize;
    input [2:0] sz;
    begin
      clampSize = (sz > `MAX_FIELD_BYTES) ? `MAX_FIELD_BYTES : sz;
    end
  endfunction

  function [31:0] satAdd;
    input [31:0] a;
    input [31:0] b;
    reg [32:0] s;
    begin
      s = {1'b0, a} + {1'b0, b};
      satAdd = s[32] ? `SUM_FULL : s[31:0];
    end
  endfunction

  // lane picks the byte for position b of a field of sz bytes
  function [7:0] pickByte;
    input [31:0] v;
    input [2:0] sz;
    input [1:0] b;
    reg [31:0] s;
    reg [1:0] lane;
    begin
      s = v;
      if (sz < `MAX_FIELD_BYTES && (v >> {sz, 3'b000}) != 32'h0000_0000)
        s = `SUM_FULL;
      if (sz == 3'd1)
        lane = 2'd0;
      else if (b == 2'd0)
        lane = 2'd1;
      else if (b == 2'd1)
        lane = 2'd0;
      else if (b == 2'd2)
        lane = (sz == 3'd3) ? 2'd2 : 2'd3;
      else
        lane = 2'd2;
      pickByte = s[{lane, 3'b000} +: 8];
    end
  endfunction

  // slots fire on the sequence where same-rate decimators present data
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1)
    begin : gDue
      assign slotDue[g] = ~subsample[g] | (seqCnt[g] == decFactor[g*FW +: FW]);
    end
  endgenerate

  // end-of-slot processing for channel finState-1 of finSlot
  wire finCh = (finState == S_FIN1);
  wire [4:0] finK = {finSlot, finCh};
  wire [2:0] ordRaw = decType[finSlot*3 +: 3];
  wire [2:0] ord = (ordRaw > `MAX_CIC_ORDER) ? `MAX_CIC_ORDER : ordRaw;
  wire bypass = subsample[finSlot] | impulseMode[finSlot];
  wire [31:0] pS = posSum[finCh];
  wire [31:0] nS = negSum[finCh];
  wire [31:0] sigIn = impulseMode[finSlot] ? pS : ((pS > nS) ? pS - nS : 32'h0000_0000);
  wire [31:0] darkIn = impulseMode[finSlot] ? 32'h0000_0000 : nS;
  wire [31:0] nbDark = bypass ? darkIn : bsDark[finK] + darkIn;
  wire [31:0] nbSig = bypass ? sigIn : bsSig[finK] + sigIn;
  reg [31:0] nInt [0:3];
  reg [31:0] nComb [0:3];
  reg [31:0] cicOut;
  reg [31:0] cz;

  always @*
  begin
    cz = 32'h0000_0000;
    for (k = 0; k < 4; k = k + 1)
    begin
      nInt[k] = integ[finK*4+k];
      nComb[k] = combDly[finK*4+k];
    end
    // integrators run every execution, combs only on output
    for (k = 0; k < 4; k = k + 1)
      if (k < ord)
        nInt[k] = integ[finK*4+k] + ((k == 0) ? sigIn : nInt[k-1]);
    if (ord != 3'd0)
      cz = nInt[ord-1];
    for (k = 0; k < 4; k = k + 1)
      if (k < ord)
      begin
        nComb[k] = cz;
        cz = cz - combDly[finK*4+k];
      end
    cicOut = cz;
  end

  wire useCic = (ord != 3'd0) && !bypass;
  wire [31:0] resSig = useCic ? cicOut : nbSig;

  // packet sizing over every active slot, due or not
  reg [`QUEUE_AW+1:0] need;
  reg [3:0] slotBytes;
  always @*
  begin
    need = statusEn ? 11'd1 : 11'd0;
    slotBytes = 4'd0;
    for (m = 0; m < NSLOT; m = m + 1)
    begin
      slotBytes = {1'b0, clampSize(darkSize[m*3 +: 3])} + {1'b0, clampSize(sigSize[m*3 +: 3])};
      if (slotActive[m])
        need = need + (ch2En[m] ? {6'd0, slotBytes, 1'b0} : {7'd0, slotBytes});
    end
  end
  wire fits = need <= (11'd`QUEUE_DEPTH - {1'b0, fifoCount});

  // byte writer cursor
  wire [4:0] wK = {wSlot, wCh};
  wire [2:0] wSize = clampSize(wFld ? sigSize[wSlot*3 +: 3] : darkSize[wSlot*3 +: 3]);
  wire [4:0] wShift = wFld ? sigShift[wSlot*5 +: 5] : darkShift[wSlot*5 +: 5];
  wire [31:0] wVal = (wFld ? stSig[wK] : stDark[wK]) >> wShift;
  wire wValid = stRdy[wK] && slotActive[wSlot] && (wSize != 3'd0) && (!wCh || ch2En[wSlot]);
  wire fldDone = !wValid || (wByte == wSize[1:0] - 2'd1);
  wire lastFld = wFld && wCh && (wSlot == NSLOT - 1);
  wire qWrite = (wState == W_DATA && wValid) || wState == W_STAT;
  wire [7:0] qByte = (wState == W_STAT) ? statusByte : pickByte(wVal, wSize, wByte);
  wire qRead = popReq && fifoCount != 0;
  assign busy = (wState != W_IDLE) || (finState != S_IDLE);

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      finState <= S_IDLE;
      finSlot <= 4'd0;
      finDue <= 1'b0;
      wState <= W_IDLE;
      wSlot <= 4'd0;
      wCh <= 1'b0;
      wFld <= 1'b0;
      wByte <= 2'd0;
      stRdy <= {NK{1'b0}};
      dataFlag <= {NSLOT{1'b0}};
      queueOverrunFlag <= 1'b0;
      queue_overrun_flag_unused_guard <= 1'b0;
      rdDark <= 32'h0000_0000;
      rdSig <= 32'h0000_0000;
      for (i = 0; i < 2; i = i + 1)
      begin
        posSum[i] <= 32'h0000_0000;
        negSum[i] <= 32'h0000_0000;
      end
      for (i = 0; i < NK*4; i = i + 1)
      begin
        integ[i] <= 32'h0000_0000;
        combDly[i] <= 32'h0000_0000;
      end
      for (i = 0; i < NK; i = i + 1)
      begin
        bsDark[i] <= 32'h0000_0000;
        bsSig[i] <= 32'h0000_0000;
        intDark[i] <= 32'h0000_0000;
        intSig[i] <= 32'h0000_0000;
        latDark[i] <= 32'h0000_0000;
        latSig[i] <= 32'h0000_0000;
        stDark[i] <= 32'h0000_0000;
        stSig[i] <= 32'h0000_0000;
      end
      for (i = 0; i < NSLOT; i = i + 1)
      begin
        decCnt[i] <= {FW{1'b0}};
        seqCnt[i] <= {FW{1'b0}};
      end
    end
    else
    begin
      rdDark <= latDark[{rdSlot, rdCh}];
      rdSig <= latSig[{rdSlot, rdCh}];
      for (i = 0; i < NK; i = i + 1)
        if (!holdRegs[i/2])
        begin
          latDark[i] <= intDark[i];
          latSig[i] <= intSig[i];
        end
      if (slotStart)
        for (i = 0; i < 2; i = i + 1)
        begin
          posSum[i] <= 32'h0000_0000;
          negSum[i] <= 32'h0000_0000;
        end
      else if (sampleValid)
      begin
        if (digIntMode ? !litRegion : pulseNegateSelect)
          negSum[sampleCh] <= satAdd(negSum[sampleCh], {{(32-ADCW){1'b0}}, adcSample});
        else
          posSum[sampleCh] <= satAdd(posSum[sampleCh], {{(32-ADCW){1'b0}}, adcSample});
      end
      // one decision per execution, shared by both channels
      if (slotEnd && finState == S_IDLE)
      begin
        finSlot <= curSlot;
        finState <= S_FIN0;
        finDue <= subsample[curSlot] | impulseMode[curSlot] |
                  (decCnt[curSlot] == decFactor[curSlot*FW +: FW]);
        if (subsample[curSlot] || decCnt[curSlot] == decFactor[curSlot*FW +: FW])
          decCnt[curSlot] <= {FW{1'b0}};
        else
          decCnt[curSlot] <= decCnt[curSlot] + 1'b1;
      end
      else if (finState != S_IDLE)
      begin
        for (j = 0; j < 4; j = j + 1)
          integ[finK*4+j] <= nInt[j];
        if (finDue)
        begin
          for (j = 0; j < 4; j = j + 1)
            combDly[finK*4+j] <= nComb[j];
          bsDark[finK] <= 32'h0000_0000;
          bsSig[finK] <= 32'h0000_0000;
          intDark[finK] <= nbDark;
          intSig[finK] <= resSig;
          stDark[finK] <= nbDark;
          stSig[finK] <= resSig;
        end
        else
        begin
          bsDark[finK] <= nbDark;
          bsSig[finK] <= nbSig;
        end
        finState <= (finState == S_FIN0 && ch2En[finSlot]) ? S_FIN1 : S_IDLE;
      end
      // flags: a set in the clear cycle wins
      for (i = 0; i < NSLOT; i = i + 1)
        if (finState == S_FIN0 && finDue && finSlot == i)
          dataFlag[i] <= 1'b1;
        else if (dataFlagClr[i])
          dataFlag[i] <= 1'b0;
      if (periodEnd && wState == W_IDLE)
      begin
        for (i = 0; i < NSLOT; i = i + 1)
          if (subsample[i])
            seqCnt[i] <= (seqCnt[i] == decFactor[i*FW +: FW]) ? {FW{1'b0}} : seqCnt[i] + 1'b1;
        if (fits)
        begin
          wState <= W_DATA;
          wSlot <= 4'd0;
          wCh <= 1'b0;
          wFld <= 1'b0;
          wByte <= 2'd0;
        end
        else
        begin
          queueOverrunFlag <= 1'b1;
          stRdy <= {NK{1'b0}};
        end
      end
      else if (overrunClr)
        queueOverrunFlag <= 1'b0;
      if (finState != S_IDLE && finDue)
        stRdy[finK] <= 1'b1;
      if (wState == W_DATA)
      begin
        if (!fldDone)
          wByte <= wByte + 2'd1;
        else
        begin
          wByte <= 2'd0;
          wFld <= ~wFld;
          if (wFld)
          begin
            wCh <= ~wCh;
            if (wCh)
              wSlot <= wSlot + 4'd1;
          end
          if (lastFld)
          begin
            stRdy <= {NK{1'b0}};
            wState <= statusEn ? W_STAT : W_IDLE;
          end
        end
      end
      else if (wState == W_STAT)
        wState <= W_IDLE;
    end
  end

  // queue storage
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      wrPtr <= {`QUEUE_AW{1'b0}};
      rdPtr <= {`QUEUE_AW{1'b0}};
      fifoCount <= {(`QUEUE_AW+1){1'b0}};
      fifoData <= `QUEUE_EMPTY_BYTE;
      queueUnderrunFlag <= 1'b0;
    end
    else
    begin
      if (qWrite)
      begin
        qMem[wrPtr] <= qByte;
        wrPtr <= wrPtr + 1'b1;
      end
      if (popReq)
      begin
        fifoData <= qRead ? qMem[rdPtr] : `QUEUE_EMPTY_BYTE;
        if (qRead)
          rdPtr <= rdPtr + 1'b1;
      end
      if (popReq && !qRead)
        queueUnderrunFlag <= 1'b1;
      else if (underrunClr)
        queueUnderrunFlag <= 1'b0;
      fifoCount <= fifoCount + {{`QUEUE_AW{1'b0}}, qWrite} - {{`QUEUE_AW{1'b0}}, qRead};
    end
  end
endmodule

// ===== test/slot_datapath_properties.sv
/*
  concurrent checks on the slot datapath ports.
  assumes one clock and the synchronous active-high reset.
*/
`timescale 1ns/10ps
module slot_datapath_properties #(
  parameter NSLOT = 12
) (
  input wire sys_clk,
  input wire rst,
  input wire popReq,
  input wire slotEnd,
  input wire [NSLOT-1:0] holdRegs,
  input wire [3:0] rdSlot,
  input wire rdCh,
  input wire overrunClr,
  input wire underrunClr,
  input wire [7:0] fifoData,
  input wire [9:0] fifoCount,
  input wire queueOverrunFlag,
  input wire queueUnderrunFlag,
  input wire [NSLOT-1:0] dataFlag,
  input wire [31:0] rdDark,
  input wire [31:0] rdSig,
  input wire busy
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  empty_read_a: assert property (popReq && fifoCount == 10'h0 && !busy |=>
    queueUnderrunFlag && fifoData == 8'hFF) else $error("empty read wrong");
  pop_count_a: assert property (popReq && fifoCount != 10'h0 && !busy |=>
    fifoCount == $past(fifoCount) - 10'h1) else $error("pop count wrong");
  count_bound_a: assert property (fifoCount <= 10'h200)
    else $error("queue above 512");
  drop_whole_a: assert property ($rose(queueOverrunFlag) && !$past(popReq) |->
    $stable(fifoCount)) else $error("partial packet written");
  idle_count_a: assert property (!busy && !$past(busy) && !$past(popReq) |->
    $stable(fifoCount)) else $error("count moved while idle");
  hold_freeze_a: assert property (&holdRegs && $past(&holdRegs) && $past(&holdRegs, 2)
    && $stable(rdSlot) && $stable(rdCh) |-> $stable(rdSig) && $stable(rdDark))
    else $error("held result moved");
  overrun_sticky_a: assert property ($fell(queueOverrunFlag) |-> $past(overrunClr))
    else $error("overrun flag dropped");
  underrun_sticky_a: assert property ($fell(queueUnderrunFlag) |-> $past(underrunClr))
    else $error("underrun flag dropped");
  flag_cause_a: assert property ((dataFlag & ~$past(dataFlag)) != 0 |->
    $past(slotEnd, 2)) else $error("data flag without slot end");
endmodule
bind slot_datapath slot_datapath_properties #(.NSLOT(NSLOT)) u_props (.sys_clk(sys_clk),
  .rst(rst), .popReq(popReq), .slotEnd(slotEnd), .holdRegs(holdRegs), .rdSlot(rdSlot),
  .rdCh(rdCh), .overrunClr(overrunClr), .underrunClr(underrunClr), .fifoData(fifoData),
  .fifoCount(fifoCount), .queueOverrunFlag(queueOverrunFlag),
  .queueUnderrunFlag(queueUnderrunFlag), .dataFlag(dataFlag), .rdDark(rdDark),
  .rdSig(rdSig), .busy(busy));

// ===== test/host_reader.sv
/*
  host model that pops queue bytes one at a time.
  assumes popped data shows just after the taking edge, in the same cycle.
*/
`timescale 1ns/10ps
module host_reader (
  input wire sys_clk,
  input wire [7:0] fifoData,
  output reg popReq
);
  initial popReq = 1'b0;
  // caller drains whole packets, so sizes never drift apart
  task pop_byte(output logic [7:0] b);
    @(posedge sys_clk);
    popReq <= 1'b1;
    @(posedge sys_clk);
    popReq <= 1'b0;
    #1 b = fifoData;
  endtask
endmodule

// ===== test/slot_datapath_tb.sv
/*
  self-checking bench: slot runs, packet writes, pops, hold and overrun.
  assumes the design with default parameters and a 100 MHz clock.
*/
`timescale 1ns/10ps
module slot_datapath_tb;
  logic sys_clk = 0, rst = 1, sampleValid = 0, sampleCh = 0, pulseNegateSelect = 0;
  logic digIntMode = 0, litRegion = 0, slotStart = 0, slotEnd = 0, periodEnd = 0;
  logic statusEn = 0, rdCh = 0, overrunClr = 0, underrunClr = 0;
  logic [13:0] adcSample = 0;
  logic [3:0] curSlot = 0, rdSlot = 0;
  logic [7:0] statusByte = 0, b;
  logic [11:0] slotActive = 0, ch2En = 0, impulseMode = 0, subsample = 0;
  logic [11:0] holdRegs = 0, dataFlagClr = 0;
  logic [95:0] decFactor = 0;
  logic [35:0] decType = 0, darkSize = 0, sigSize = 0;
  logic [59:0] darkShift = 0, sigShift = 0;
  logic [7:0] pkt [9] = '{0, 1, 0, 0, 8'h7F, 8'hFD, 0, 0, 8'hA5};
  wire popReq, busy, queueOverrunFlag, queueUnderrunFlag;
  wire [7:0] fifoData;
  wire [9:0] fifoCount;
  wire [11:0] dataFlag, slotDue;
  wire [31:0] rdDark, rdSig;
  int failures = 0, cmpCount = 0, cyc = 0;
  slot_datapath u_slot_datapath (.sys_clk(sys_clk), .rst(rst), .sampleValid(sampleValid),
    .sampleCh(sampleCh), .adcSample(adcSample), .pulseNegateSelect(pulseNegateSelect),
    .digIntMode(digIntMode), .litRegion(litRegion), .slotStart(slotStart),
    .slotEnd(slotEnd), .curSlot(curSlot), .periodEnd(periodEnd), .slotActive(slotActive),
    .ch2En(ch2En), .impulseMode(impulseMode), .subsample(subsample), .decFactor(decFactor),
    .decType(decType), .darkShift(darkShift), .sigShift(sigShift), .darkSize(darkSize),
    .sigSize(sigSize), .holdRegs(holdRegs), .statusEn(statusEn), .statusByte(statusByte),
    .popReq(popReq), .rdSlot(rdSlot), .rdCh(rdCh), .dataFlagClr(dataFlagClr),
    .overrunClr(overrunClr), .underrunClr(underrunClr), .fifoData(fifoData),
    .fifoCount(fifoCount), .queue_overrun_flag_unused_guard(),
    .queueOverrunFlag(queueOverrunFlag), .queueUnderrunFlag(queueUnderrunFlag),
    .dataFlag(dataFlag), .rdDark(rdDark), .rdSig(rdSig), .slotDue(slotDue), .busy(busy));
  host_reader u_host_reader (.sys_clk(sys_clk), .fifoData(fifoData), .popReq(popReq));
  initial forever #5 sys_clk = ~sys_clk;
  task close_out;
    if (failures == 0 && cmpCount > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      failures++;
      close_out;
    end
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task popx(input logic [7:0] exp);
    u_host_reader.pop_byte(b);
    check(b, exp);
  endtask
  // two lit samples and one dark one; dim selects digital integration
  task slot_run(input logic dim, input logic [13:0] p1, p2, n1);
    @(posedge sys_clk) slotStart <= 1;
    @(posedge sys_clk) slotStart <= 0;
    sampleValid <= 1;
    adcSample <= p1;
    digIntMode <= dim;
    pulseNegateSelect <= dim;
    litRegion <= 1;
    @(posedge sys_clk) adcSample <= p2;
    @(posedge sys_clk) adcSample <= n1;
    pulseNegateSelect <= !dim;
    litRegion <= 0;
    @(posedge sys_clk) sampleValid <= 0;
    slotEnd <= 1;
    @(posedge sys_clk) slotEnd <= 0;
    repeat (6) @(posedge sys_clk);
    #1;
  endtask
  task period;
    @(posedge sys_clk) periodEnd <= 1;
    @(posedge sys_clk) periodEnd <= 0;
    // the writer walks every slot, channel and field, skipped ones included
    repeat (100)
    begin
      @(posedge sys_clk);
      #1;
      if (!busy) break;
    end
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 0;
    @(posedge sys_clk);
    #1;
    check(fifoData, 8'hFF);
    check(fifoCount, 10'h0);
    check(slotDue, 12'hFFF);
    popx(8'hFF);
    check(queueUnderrunFlag, 1'b1);
    @(posedge sys_clk) underrunClr <= 1;
    @(posedge sys_clk) underrunClr <= 0;
    slotActive <= 12'h1;
    darkSize <= 36'h1;
    sigSize <= 36'h2;
    sigShift <= 60'h1;
    statusEn <= 1;
    statusByte <= 8'hA5;
    slot_run(0, 14'h190, 14'hC8, 14'h12C);
    check(queueUnderrunFlag, 1'b0);
    check(dataFlag[0], 1'b1);
    check(rdSig, 32'h12C);
    check(rdDark, 32'h12C);
    period;
    check(fifoCount, 10'h4);
    popx(8'hFF);
    popx(8'h0);
    popx(8'h96);
    popx(8'hA5);
    @(posedge sys_clk) holdRegs <= 12'hFFF;
    slot_run(1, 14'hA, 14'h14, 14'h32);
    check(rdSig, 32'h12C);
    @(posedge sys_clk) holdRegs <= 0;
    repeat (3) @(posedge sys_clk);
    #1;
    check(rdSig, 32'h0);
    check(rdDark, 32'h32);
    period;
    popx(8'h32);
    popx(8'h0);
    popx(8'h0);
    popx(8'hA5);
    @(posedge sys_clk) darkSize <= 36'h4;
    sigSize <= 36'h4;
    sigShift <= 0;
    // 56 packets of 9 bytes fit, the 57th must be dropped
    repeat (57)
    begin
      slot_run(0, 14'h3FFF, 14'h3FFF, 14'h1);
      period;
    end
    check(fifoCount, 10'h1F8);
    check(queueOverrunFlag, 1'b1);
    for (int i = 0; i < 9; i++) popx(pkt[i]);
    close_out;
  end
endmodule
